// ==== ssafi_host.sv ====
// Host model: drives frame select and serial clock, shifts in the word.
// Assumes the device samples both pins on clk_sys_in.
`timescale 1ns/1ps
module ssafi_host
(
  input wire logic clk_sys_in,
  input wire logic serial_result_in,
  input wire logic oe_in,
  output logic frame_sel_n_out,
  output logic sclk_out
);
  initial frame_sel_n_out = 1'b1;
  initial sclk_out = 1'b1;
  // Eleven system clocks per serial clock, just under the fastest rate allowed.
  // A released output reads as the inverse of its last bit, so a bit taken
  // while the output is off spoils the word.
  task automatic frame(input int falls, output logic [15:0] word, output logic oe_end);
    word = 16'h0000;
    @(posedge clk_sys_in) frame_sel_n_out <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    for (int i = 0; i < falls; i++)
    begin
      @(negedge clk_sys_in) word = {word[14:0], oe_in ? serial_result_in : ~serial_result_in};
      @(posedge clk_sys_in) sclk_out <= 1'b0;
      repeat (5) @(posedge clk_sys_in);
      sclk_out <= 1'b1;
      repeat (5) @(posedge clk_sys_in);
    end
    @(negedge clk_sys_in) oe_end = oe_in;
    @(posedge clk_sys_in) frame_sel_n_out <= 1'b1;
    repeat (11) @(posedge clk_sys_in);
  endtask
endmodule

// ==== ssafi_pkg.sv ====
// Shared types and constants for the serial SAR converter frame interface.
// Assumes one system clock at 250 MHz; host pins are synchronous to it.
// ----------------------------------------------------------------------------
// Function
// ----------------------------------------------------------------------------
// Function
// - Frame select fall samples input, starts frame.
// - Serial clock alone paces conversion and shifting.
// - First zero driven right after frame select falls.
// - Output advances on each serial clock fall.
// - Output released after sixteenth falling edge.
// - Rise between edges two and ten: power-down.
// - First result after power-up is invalid.
// - Word: leading zeros, MSB-first data, trailing zeros.
// - Conversion ends edge fourteen (ten-bit), twelve (eight).
// - Select rise aborts conversion, output tri-stated.
package ssafi_pkg;

  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned QUIET_TIME_PS = 40000;
  localparam int unsigned QUIET_CYCLES = QUIET_TIME_PS / CLK_PERIOD_PS;
  localparam int unsigned POWERUP_TIME_PS = 800000;
  localparam int unsigned POWERUP_CYCLES = POWERUP_TIME_PS / CLK_PERIOD_PS;
  localparam int unsigned WORD_BITS = 16;
  localparam int unsigned LEAD_ZEROS = 4;
  localparam logic [4:0] EDGE_PD_LO = 5'h02;
  localparam logic [4:0] EDGE_PD_HI = 5'h0a;
  localparam logic [4:0] EDGE_LAST = 5'h10;

  typedef enum logic [2:0] {
    SSAFI_IDLE = 3'b001,
    SSAFI_SHIFT = 3'b010,
    SSAFI_DONE = 3'b100
  } ssafi_state_t;

  typedef struct packed {
    logic data;
    logic oe;
  } ssafi_pin_t;

endpackage

// ==== ssafi_top.sv ====
// Frame sequencer and serial shifter of the sampling converter.
// Assumes frame select and serial clock arrive synchronous to clk_sys_in.
`timescale 1ns/1ps
module ssafi_top
#(
  parameter int unsigned RES_BITS = 10
)
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic frame_sel_n_in,
  input wire logic sclk_in,
  input wire logic [RES_BITS-1:0] analog_input,
  output logic serial_result_out,
  output logic serial_result_oe_out,
  output logic powered_down_out,
  output logic result_invalid_out,
  output logic conv_done_out
);

  // --------------------------------------------------------------------------
  // Edge detection
  // --------------------------------------------------------------------------
  logic sel_n_q;
  logic sclk_q;
  logic sel_fall;
  logic sel_rise;
  logic sclk_fall;
  localparam logic [4:0] CONV_EDGE = 5'(ssafi_pkg::LEAD_ZEROS + RES_BITS);

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sel_n_q <= 1'b1;
      sclk_q <= 1'b1;
    end
    else
    begin
      sel_n_q <= frame_sel_n_in;
      sclk_q <= sclk_in;
    end
  end

  assign sel_fall = sel_n_q & ~frame_sel_n_in;
  assign sel_rise = ~sel_n_q & frame_sel_n_in;
  assign sclk_fall = sclk_q & ~sclk_in;

  // --------------------------------------------------------------------------
  // Frame state, edge count, shifter
  // --------------------------------------------------------------------------
  ssafi_pkg::ssafi_state_t state_q;
  logic [4:0] edge_cnt_q;
  logic [ssafi_pkg::WORD_BITS-1:0] word_q;

  // The shifter holds the sampled code padded to a full word; shifting out
  // zeros beyond the result gives the trailing pad for either width.
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_q <= ssafi_pkg::SSAFI_IDLE;
      edge_cnt_q <= 5'h00;
      word_q <= '0;
    end
    else if (frame_sel_n_in && state_q != ssafi_pkg::SSAFI_IDLE)
    begin
      state_q <= ssafi_pkg::SSAFI_IDLE;
    end
    else if (sel_fall)
    begin
      state_q <= ssafi_pkg::SSAFI_SHIFT;
      edge_cnt_q <= 5'h00;
      word_q <= {{ssafi_pkg::LEAD_ZEROS{1'b0}}, analog_input,
                 {(ssafi_pkg::WORD_BITS-ssafi_pkg::LEAD_ZEROS-RES_BITS){1'b0}}};
    end
    else if (sclk_fall && state_q == ssafi_pkg::SSAFI_SHIFT)
    begin
      edge_cnt_q <= edge_cnt_q + 5'h01;
      word_q <= {word_q[ssafi_pkg::WORD_BITS-2:0], 1'b0};
      if (edge_cnt_q + 5'h01 == ssafi_pkg::EDGE_LAST)
        state_q <= ssafi_pkg::SSAFI_DONE;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      serial_result_out <= 1'b0;
      serial_result_oe_out <= 1'b0;
      conv_done_out <= 1'b0;
    end
    else
    begin
      serial_result_oe_out <= (state_q == ssafi_pkg::SSAFI_SHIFT) && !frame_sel_n_in
                              && !(sclk_fall && edge_cnt_q == ssafi_pkg::EDGE_LAST - 5'h01);
      serial_result_out <= sel_fall ? 1'b0 : word_q[ssafi_pkg::WORD_BITS-1];
      conv_done_out <= sclk_fall && state_q == ssafi_pkg::SSAFI_SHIFT && !frame_sel_n_in
                       && (edge_cnt_q + 5'h01 == CONV_EDGE);
    end
  end

  // --------------------------------------------------------------------------
  // Power-down and invalid first result
  // --------------------------------------------------------------------------
  // Power-down is modelled as a flag; a wake frame needs more than ten edges.
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      powered_down_out <= 1'b0;
      result_invalid_out <= 1'b1;
    end
    else if (sel_rise && state_q == ssafi_pkg::SSAFI_SHIFT
             && edge_cnt_q >= ssafi_pkg::EDGE_PD_LO && edge_cnt_q < ssafi_pkg::EDGE_PD_HI)
    begin
      powered_down_out <= 1'b1;
      result_invalid_out <= 1'b1;
    end
    else if (sclk_fall && state_q == ssafi_pkg::SSAFI_SHIFT && !frame_sel_n_in
             && edge_cnt_q == ssafi_pkg::EDGE_PD_HI)
    begin
      if (powered_down_out)
        powered_down_out <= 1'b0;
      else
        result_invalid_out <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  property p_first_zero;
    @(posedge clk_sys_in) disable iff (rst_in)
    sel_fall |=> !serial_result_out;
  endproperty
  a_first_zero: assert property (p_first_zero) else $error("first bit not zero");

  property p_release;
    @(posedge clk_sys_in) disable iff (rst_in)
    frame_sel_n_in && $past(frame_sel_n_in) |=> !serial_result_oe_out;
  endproperty
  a_release: assert property (p_release) else $error("output driven while deselected");

  property p_pd_enter;
    @(posedge clk_sys_in) disable iff (rst_in)
    sel_rise && state_q == ssafi_pkg::SSAFI_SHIFT && edge_cnt_q == 5'h05 |=> powered_down_out;
  endproperty
  a_pd_enter: assert property (p_pd_enter) else $error("power-down not entered");

  property p_done_off;
    @(posedge clk_sys_in) disable iff (rst_in)
    state_q == ssafi_pkg::SSAFI_DONE |=> !serial_result_oe_out;
  endproperty
  a_done_off: assert property (p_done_off) else $error("output not released");

  // A frame opens over two clocks: the select fall is taken, then the select
  // must still be low when the pin is first driven.
  sequence s_frame_start;
    sel_fall ##1 !frame_sel_n_in;
  endsequence

  sequence s_fall_in_frame;
    sclk_fall && state_q == ssafi_pkg::SSAFI_SHIFT && !frame_sel_n_in;
  endsequence

  property p_frame_open;
    @(posedge clk_sys_in) disable iff (rst_in)
    s_frame_start |=> serial_result_oe_out && !serial_result_out;
  endproperty
  a_frame_open: assert property (p_frame_open) else $error("first bit not driven");

  // The pin lags the shifter by one clock, so the bit seen two clocks after a
  // fall is the one that sat second from the top when the fall came.
  property p_shift_out;
    @(posedge clk_sys_in) disable iff (rst_in)
    s_fall_in_frame |=> ##1 serial_result_out == $past(word_q[ssafi_pkg::WORD_BITS-2], 2);
  endproperty
  a_shift_out: assert property (p_shift_out) else $error("wrong bit after clock fall");

  property p_conv_done;
    @(posedge clk_sys_in) disable iff (rst_in)
    s_fall_in_frame ##0 (edge_cnt_q == CONV_EDGE - 5'h01) |=> conv_done_out;
  endproperty
  a_conv_done: assert property (p_conv_done) else $error("conversion end missed");

  property p_conv_pulse;
    @(posedge clk_sys_in) disable iff (rst_in)
    conv_done_out |=> !conv_done_out;
  endproperty
  a_conv_pulse: assert property (p_conv_pulse) else $error("pulse too long");

  property p_pd_late;
    @(posedge clk_sys_in) disable iff (rst_in)
    sel_rise && state_q != ssafi_pkg::SSAFI_IDLE && edge_cnt_q >= ssafi_pkg::EDGE_PD_HI
      && !powered_down_out |=> !powered_down_out;
  endproperty
  a_pd_late: assert property (p_pd_late) else $error("late select rise powered down");

  property p_wake;
    @(posedge clk_sys_in) disable iff (rst_in)
    s_fall_in_frame ##0 (edge_cnt_q == ssafi_pkg::EDGE_PD_HI && powered_down_out)
      |=> !powered_down_out && result_invalid_out;
  endproperty
  a_wake: assert property (p_wake) else $error("dummy frame did not wake");

  property p_pd_invalid;
    @(posedge clk_sys_in) disable iff (rst_in)
    sel_rise && state_q == ssafi_pkg::SSAFI_SHIFT && edge_cnt_q >= ssafi_pkg::EDGE_PD_LO
      && edge_cnt_q < ssafi_pkg::EDGE_PD_HI |=> powered_down_out && result_invalid_out;
  endproperty
  a_pd_invalid: assert property (p_pd_invalid) else $error("invalid flag not set");

  property p_abort;
    @(posedge clk_sys_in) disable iff (rst_in)
    frame_sel_n_in && state_q != ssafi_pkg::SSAFI_IDLE |=> state_q == ssafi_pkg::SSAFI_IDLE;
  endproperty
  a_abort: assert property (p_abort) else $error("frame not aborted");

endmodule

// ==== tb_ssafi_top.sv ====
// Testbench: host model runs frames, results compared with an integer model.
// Assumes ssafi_host as the far side of ssafi_top.
`timescale 1ns/1ps
module tb_ssafi_top;
  localparam int RES = 10;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic [RES-1:0] ain = '0;
  logic sel_n, sclk, serial_result, oe, pd, inv, done, oe_end;
  logic [15:0] word;
  int n_mismatch = 0;
  int cmp_count = 0;
  int n_conv = 0;
  int cyc = 0;
  int exp_q[$];
  int last_exp = 0;
  always #2 clk_sys_in = ~clk_sys_in;
  ssafi_top #(.RES_BITS(RES)) u_ssafi_top (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .frame_sel_n_in(sel_n), .sclk_in(sclk), .analog_input(ain),
    .serial_result_out(serial_result),
    .serial_result_oe_out(oe), .powered_down_out(pd), .result_invalid_out(inv),
    .conv_done_out(done));
  ssafi_host u_ssafi_host (.clk_sys_in(clk_sys_in), .serial_result_in(serial_result),
    .oe_in(oe),
    .frame_sel_n_out(sel_n), .sclk_out(sclk));
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic run(input int falls);
    n_conv = 0;
    u_ssafi_host.frame(falls, word, oe_end);
    $display("frame of %0d falls done", falls);
  endtask
  // Integer model: four leading zeros, the code, then zero padding to 16 bits.
  task automatic new_code();
    int code;
    code = int'($urandom) & ((1 << RES) - 1);
    @(posedge clk_sys_in) ain <= RES'(code);
    last_exp = code << (16 - 4 - RES);
    exp_q.push_back(last_exp);
  endtask
  // A hang ends the run as a mismatch.
  always @(posedge clk_sys_in)
  begin
    cyc++;
    if (done === 1'b1)
      n_conv++;
    if (cyc == 6000)
    begin
      n_mismatch++;
      print_verdict();
    end
  end
  initial
  begin
    void'($urandom(75649));
    repeat (6) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(posedge clk_sys_in);
    check(16'(inv), 16'h0001);
    for (int k = 0; k < 4; k++)
    begin
      new_code();
      run(16);
      if (k > 0)
        check(word, 16'(exp_q.pop_front()));
      else
        exp_q.delete(0);
      check({oe_end, oe, 14'(n_conv)}, 16'h0001);
    end
    check(16'(inv), 16'h0000);
    run(5);
    check({oe, pd, 14'(n_conv)}, 16'h4000);
    run(11);
    check(16'({pd, inv}), 16'h0001);
    run(12);
    check({oe, pd, 14'(n_conv)}, 16'h0000);
    new_code();
    run(16);
    check(word, 16'(exp_q.pop_front()));
    run(16);
    check(word, 16'(last_exp));
    check(16'(inv), 16'h0000);
    print_verdict();
  end
endmodule
